// ==== hdl/ptr_map.vh ====
// constants for the receive payload pointer interpreter
`ifndef PTR_MAP_VH
`define PTR_MAP_VH

// register byte offsets
`define PTR_ADDR_CTRL      8'h00
`define PTR_ADDR_ALARM     8'h04
`define PTR_ADDR_PEND      8'h08
`define PTR_ADDR_STATUS    8'h0c

// control register fields
`define PTR_CTRL_SDH       0
`define PTR_CTRL_AIS_MSK_A 4
`define PTR_CTRL_AIS_MSK_B 5
`define PTR_CTRL_LOP_MSK_A 6
`define PTR_CTRL_LOP_MSK_B 7
`define PTR_CTRL_RESET     8'h00

// alarm / pending fields
`define PTR_BIT_AIS        0
`define PTR_BIT_LOP        1

// status register fields
`define PTR_STAT_STATE_LO  0
`define PTR_STAT_CI_BAD    4
`define PTR_STAT_VAL_LO    16

// pointer word fields and codes
`define PTR_FLAG_HI        15
`define PTR_FLAG_LO        12
`define PTR_SS_HI          11
`define PTR_SS_LO          10
`define PTR_NDF_ON         4'h9
`define PTR_NDF_OFF        4'h6
`define PTR_SS_SDH         2'h2
`define PTR_AIS_WORD       16'hffff
`define PTR_CI_VALUE       10'h3ff
`define PTR_I_BITS         10'h2aa
`define PTR_D_BITS         10'h155
`define PTR_MAX_VALUE      10'h30e
`define PTR_VALUE_RESET    10'h000

// majorities and persistence counts (frames)
`define PTR_FLAG_MAJ       4'h3
`define PTR_SONET_MAJ      4'h8
`define PTR_SDH_MAJ        4'h3
`define PTR_SDH_MIN        4'h2
`define PTR_STATE_NORMAL_PERSIST   2'h3
`define PTR_AIS_PERSIST    2'h3
`define PTR_INV_PERSIST    4'h8
`define PTR_JUST_HOLD      2'h3

// bus responses
`define PTR_RESP_OKAY      2'h0
`define PTR_RESP_SLVERR    2'h2

`endif

// ==== hdl/ptr_classify.v ====
// pointer word classifier, purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "ptr_map.vh"

module ptr_classify (
	// pointer word and reference
	input  wire [15:0] ptr_word,
	input  wire [9:0]  cur_value,
	input  wire        sdh_mode,
	// classification
	output wire        flag_enabled,
	output wire        flag_normal,
	output wire        ss_match,
	output wire        in_range,
	output wire        ais_word,
	output wire        is_inc,
	output wire        is_dec,
	output wire        ci_normal,
	output wire        ci_ais
);

	// count of set bits in a ten-bit vector
	function [3:0] ones10;
		input [9:0] v;
		integer k;
		begin
			ones10 = 4'h0;
			for (k = 0; k < 10; k = k + 1) begin
				ones10 = ones10 + {3'h0, v[k]};
			end
		end
	endfunction

	wire [3:0] flag  = ptr_word[`PTR_FLAG_HI:`PTR_FLAG_LO];
	wire [9:0] value = ptr_word[9:0];
	wire [9:0] diff;
	wire [9:0] inc_match;
	wire [9:0] dec_match;

	// masks as named constants, a bare literal cannot be bit-selected
	localparam [9:0] I_MASK = `PTR_I_BITS;
	localparam [9:0] D_MASK = `PTR_D_BITS;

	genvar b;
	generate
		for (b = 0; b < 10; b = b + 1) begin : g_bit
			assign diff[b]      = value[b] ^ cur_value[b];
			assign inc_match[b] = ~(diff[b] ^ I_MASK[b]);
			assign dec_match[b] = ~(diff[b] ^ D_MASK[b]);
		end
	endgenerate

	wire [3:0] i_inv = ones10(diff & `PTR_I_BITS);
	wire [3:0] d_inv = ones10(diff & `PTR_D_BITS);

	assign flag_enabled = ones10({6'h00, ~(flag ^ `PTR_NDF_ON)}) >= `PTR_FLAG_MAJ;
	assign flag_normal  = ones10({6'h00, ~(flag ^ `PTR_NDF_OFF)}) >= `PTR_FLAG_MAJ;

	assign ss_match = ~sdh_mode | (ptr_word[`PTR_SS_HI:`PTR_SS_LO] == `PTR_SS_SDH);
	assign in_range = value <= `PTR_MAX_VALUE;
	assign ais_word = ptr_word == `PTR_AIS_WORD;

	assign is_inc = flag_normal & (sdh_mode ?
		(i_inv >= `PTR_SDH_MAJ) && (d_inv <= `PTR_SDH_MIN) :
		(ones10(inc_match) >= `PTR_SONET_MAJ));

	assign is_dec = flag_normal & (sdh_mode ?
		(d_inv >= `PTR_SDH_MAJ) && (i_inv <= `PTR_SDH_MIN) :
		(ones10(dec_match) >= `PTR_SONET_MAJ));

	assign ci_normal = flag_normal & (value == `PTR_CI_VALUE) & ss_match;
	assign ci_ais    = ais_word;

endmodule // ptr_classify
`default_nettype wire

// ==== hdl/ptr_interp.v ====
// receive payload pointer interpreter with axi4-lite registers
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "ptr_map.vh"

module ptr_interp (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// received overhead stream
	input  wire        ptr_strobe,
	input  wire [15:0] ptr_word,
	input  wire        ci_strobe,
	input  wire [15:0] ci_word,
	input  wire        frame_end,
	// axi4-lite write address
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// axi4-lite read address
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	// axi4-lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// alarms and interrupts
	output reg         path_ais,
	output reg         path_lop,
	output reg  [9:0]  pointer_value,
	output reg         irq_out_a,
	output reg         irq_out_b
);

	localparam [1:0] STATE_NORMAL            = 2'h0;
	localparam [1:0] STATE_LOSS_OF_POINTER   = 2'h1;
	localparam [1:0] STATE_ALARM_INDICATION  = 2'h2;

	reg [1:0]  state_q;
	reg [1:0]  state_d;
	reg [9:0]  cur_q;
	reg [9:0]  cur_d;
	reg [9:0]  cand_q;
	reg [9:0]  cand_d;
	reg [1:0]  state_normal_cnt_q;
	reg [1:0]  state_normal_cnt_d;
	reg [1:0]  ais_cnt_q;
	reg [1:0]  ais_cnt_d;
	reg [3:0]  inv_cnt_q;
	reg [3:0]  inv_cnt_d;
	reg [1:0]  hold_q;
	reg [1:0]  hold_d;
	reg [15:0] prim_q;
	reg        prim_seen_q;
	reg        ci_bad_q;
	reg        ci_bad_last_q;
	reg [7:0]  ctrl_q;
	reg        path_ais_alarm_latch_q;
	reg        path_lop_alarm_latch_q;
	reg        path_ais_pending_q;
	reg        path_lop_pending_q;
	reg        valid_now;

	wire sdh_mode = ctrl_q[`PTR_CTRL_SDH];

	// classification of the held primary pointer
	wire p_ndf;
	wire p_state_normal;
	wire p_ss;
	wire p_range;
	wire p_ais;
	wire p_inc;
	wire p_dec;

	ptr_classify u_prim (
		.ptr_word     (prim_q),
		.cur_value    (cur_q),
		.sdh_mode     (sdh_mode),
		.flag_enabled (p_ndf),
		.flag_normal  (p_state_normal),
		.ss_match     (p_ss),
		.in_range     (p_range),
		.ais_word     (p_ais),
		.is_inc       (p_inc),
		.is_dec       (p_dec),
		.ci_normal    (),
		.ci_ais       ()
	);

	// classification of each concat pair as it arrives
	wire c_normal;
	wire c_ais;

	ptr_classify u_ci (
		.ptr_word     (ci_word),
		.cur_value    (cur_q),
		.sdh_mode     (sdh_mode),
		.flag_enabled (),
		.flag_normal  (),
		.ss_match     (),
		.in_range     (),
		.ais_word     (),
		.is_inc       (),
		.is_dec       (),
		.ci_normal    (c_normal),
		.ci_ais       (c_ais)
	);

	// evaluate only when a frame delivered its primary pointer
	wire frame_eval = frame_end & prim_seen_q;
	wire [9:0] pval = prim_q[9:0];

	// a bad concat pair spoils the frame for all but the ais check
	wire good    = p_ss & ~ci_bad_q;
	wire ndf_ok  = p_ndf & p_range & good;
	wire state_normal_ok = p_state_normal & p_range & good;
	wire ais_ok  = p_ais;

	wire just_ok = (state_q == STATE_NORMAL) && (hold_q == 2'h0) && good;
	wire inc_ok  = just_ok & p_inc;
	wire dec_ok  = just_ok & p_dec & ~p_inc;

	// next value after one justification step, wrapping at 782
	wire [9:0] cur_inc = (cur_q == `PTR_MAX_VALUE) ? 10'h000 : cur_q + 10'h001;
	wire [9:0] cur_dec = (cur_q == 10'h000) ? `PTR_MAX_VALUE : cur_q - 10'h001;

	always @* begin
		case (state_q)
			STATE_ALARM_INDICATION: valid_now = ais_ok;
			STATE_NORMAL: valid_now = ndf_ok | inc_ok | dec_ok | (state_normal_ok & (pval == cur_q));
			default: valid_now = 1'b1;
		endcase
	end

	// frame evaluation and state machine
	always @* begin
		state_d    = state_q;
		cur_d      = cur_q;
		cand_d     = cand_q;
		state_normal_cnt_d = state_normal_cnt_q;
		ais_cnt_d  = ais_cnt_q;
		inv_cnt_d  = inv_cnt_q;
		hold_d     = hold_q;
		if (frame_eval) begin
			hold_d = (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;
			// run of identical normal pointers
			if (state_normal_ok && !p_inc && !p_dec || state_normal_ok && state_q != STATE_NORMAL) begin
				if (state_normal_cnt_q != 2'h0 && pval == cand_q) begin
					if (state_normal_cnt_q != `PTR_STATE_NORMAL_PERSIST)
						state_normal_cnt_d = state_normal_cnt_q + 2'h1;
				end else begin
					cand_d     = pval;
					state_normal_cnt_d = 2'h1;
				end
			end else begin
				state_normal_cnt_d = 2'h0;
			end
			// run of ais pointers
			if (ais_ok) begin
				if (ais_cnt_q != `PTR_AIS_PERSIST)
					ais_cnt_d = ais_cnt_q + 2'h1;
			end else begin
				ais_cnt_d = 2'h0;
			end
			// run of invalid pointers
			if (valid_now)
				inv_cnt_d = 4'h0;
			else if (inv_cnt_q != `PTR_INV_PERSIST)
				inv_cnt_d = inv_cnt_q + 4'h1;
			case (state_q)
				STATE_NORMAL: begin
					if (ndf_ok) begin
						cur_d  = pval;
						hold_d = `PTR_JUST_HOLD;
					end else if (inc_ok) begin
						cur_d  = cur_inc;
						hold_d = `PTR_JUST_HOLD;
					end else if (dec_ok) begin
						cur_d  = cur_dec;
						hold_d = `PTR_JUST_HOLD;
					end else if (state_normal_cnt_d == `PTR_STATE_NORMAL_PERSIST) begin
						cur_d = cand_d;
					end
					if (ais_cnt_d == `PTR_AIS_PERSIST) begin
						state_d   = STATE_ALARM_INDICATION;
						inv_cnt_d = 4'h0;
					end else if (inv_cnt_d == `PTR_INV_PERSIST) begin
						state_d   = STATE_LOSS_OF_POINTER;
						inv_cnt_d = 4'h0;
					end
				end
				STATE_LOSS_OF_POINTER: begin
					inv_cnt_d = 4'h0;
					if (state_normal_cnt_d == `PTR_STATE_NORMAL_PERSIST) begin
						state_d = STATE_NORMAL;
						cur_d   = cand_d;
					end else if (ais_cnt_d == `PTR_AIS_PERSIST) begin
						state_d = STATE_ALARM_INDICATION;
					end
				end
				STATE_ALARM_INDICATION: begin
					if (state_normal_cnt_d == `PTR_STATE_NORMAL_PERSIST) begin
						state_d   = STATE_NORMAL;
						cur_d     = cand_d;
						inv_cnt_d = 4'h0;
					end else if (inv_cnt_d == `PTR_INV_PERSIST) begin
						state_d   = STATE_LOSS_OF_POINTER;
						inv_cnt_d = 4'h0;
					end
				end
				default: begin
					state_d = STATE_LOSS_OF_POINTER;
				end
			endcase
		end
	end

	// alarm state change events
	wire ais_now = state_q == STATE_ALARM_INDICATION;
	wire lop_now = state_q == STATE_LOSS_OF_POINTER;
	wire ais_evt = ais_now != (state_d == STATE_ALARM_INDICATION);
	wire lop_evt = lop_now != (state_d == STATE_LOSS_OF_POINTER);

	// bus handshakes: write needs address and data together
	wire wr_hs = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire rd_hs = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_awready = wr_hs;
	assign s_axi_wready  = wr_hs;
	assign s_axi_arready = ~s_axi_rvalid;

	wire rd_alarm = rd_hs && (s_axi_araddr == `PTR_ADDR_ALARM);
	wire rd_pend  = rd_hs && (s_axi_araddr == `PTR_ADDR_PEND);

	// read mux, values before any read side effect
	reg [31:0] rd_data;
	reg        rd_err;
	always @* begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (s_axi_araddr == `PTR_ADDR_CTRL) begin
			rd_data[7:0] = ctrl_q;
		end else if (s_axi_araddr == `PTR_ADDR_ALARM) begin
			rd_data[`PTR_BIT_AIS] = path_ais_alarm_latch_q;
			rd_data[`PTR_BIT_LOP] = path_lop_alarm_latch_q;
		end else if (s_axi_araddr == `PTR_ADDR_PEND) begin
			rd_data[`PTR_BIT_AIS] = path_ais_pending_q;
			rd_data[`PTR_BIT_LOP] = path_lop_pending_q;
		end else if (s_axi_araddr == `PTR_ADDR_STATUS) begin
			rd_data[`PTR_STAT_STATE_LO+1:`PTR_STAT_STATE_LO] = state_q;
			rd_data[`PTR_STAT_CI_BAD] = ci_bad_last_q;
			rd_data[`PTR_STAT_VAL_LO+9:`PTR_STAT_VAL_LO] = cur_q;
		end else begin
			rd_err = 1'b1;
		end
	end

	// all clocked state, synchronous reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q                <= STATE_LOSS_OF_POINTER;
			cur_q                  <= `PTR_VALUE_RESET;
			cand_q                 <= `PTR_VALUE_RESET;
			state_normal_cnt_q             <= 2'h0;
			ais_cnt_q              <= 2'h0;
			inv_cnt_q              <= 4'h0;
			hold_q                 <= 2'h0;
			prim_q                 <= 16'h0000;
			prim_seen_q            <= 1'b0;
			ci_bad_q               <= 1'b0;
			ci_bad_last_q          <= 1'b0;
			ctrl_q                 <= `PTR_CTRL_RESET;
			path_ais_alarm_latch_q <= 1'b0;
			path_lop_alarm_latch_q <= 1'b0;
			path_ais_pending_q     <= 1'b0;
			path_lop_pending_q     <= 1'b0;
			s_axi_bvalid           <= 1'b0;
			s_axi_bresp            <= `PTR_RESP_OKAY;
			s_axi_rvalid           <= 1'b0;
			s_axi_rdata            <= 32'h0000_0000;
			s_axi_rresp            <= `PTR_RESP_OKAY;
			path_ais               <= 1'b0;
			path_lop               <= 1'b0;
			pointer_value          <= `PTR_VALUE_RESET;
			irq_out_a              <= 1'b0;
			irq_out_b              <= 1'b0;
		end else begin
			state_q    <= state_d;
			cur_q      <= cur_d;
			cand_q     <= cand_d;
			state_normal_cnt_q <= state_normal_cnt_d;
			ais_cnt_q  <= ais_cnt_d;
			inv_cnt_q  <= inv_cnt_d;
			hold_q     <= hold_d;
			if (ptr_strobe) begin
				prim_q      <= ptr_word;
				prim_seen_q <= 1'b1;
			end else if (frame_end) begin
				prim_seen_q <= 1'b0;
			end
			// any invalid concat pair before the frame end marks the frame
			if (frame_end) begin
				ci_bad_q      <= 1'b0;
				ci_bad_last_q <= ci_bad_q;
			end else if (ci_strobe && !c_normal && !c_ais) begin
				ci_bad_q <= 1'b1;
			end
			// control register, low byte lane only
			if (wr_hs && s_axi_awaddr == `PTR_ADDR_CTRL && s_axi_wstrb[0])
				ctrl_q <= s_axi_wdata[7:0];
			// latch-high, event wins over read reload
			path_ais_alarm_latch_q <= ais_evt | (rd_alarm ? ais_now : path_ais_alarm_latch_q);
			path_lop_alarm_latch_q <= lop_evt | (rd_alarm ? lop_now : path_lop_alarm_latch_q);
			path_ais_pending_q <= ais_evt | (path_ais_pending_q & ~rd_pend);
			path_lop_pending_q <= lop_evt | (path_lop_pending_q & ~rd_pend);
			// write response, unmapped or read-only offsets answer slverr
			if (wr_hs) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr == `PTR_ADDR_CTRL) ? `PTR_RESP_OKAY
					: `PTR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// read response
			if (rd_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_err ? `PTR_RESP_SLVERR : `PTR_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			// status pins follow the state and pointer registers, interrupts the masked pending bits
			path_ais      <= state_d == STATE_ALARM_INDICATION;
			path_lop      <= state_d == STATE_LOSS_OF_POINTER;
			pointer_value <= cur_d;
			irq_out_a <= (path_ais_pending_q & ctrl_q[`PTR_CTRL_AIS_MSK_A])
				| (path_lop_pending_q & ctrl_q[`PTR_CTRL_LOP_MSK_A]);
			irq_out_b <= (path_ais_pending_q & ctrl_q[`PTR_CTRL_AIS_MSK_B])
				| (path_lop_pending_q & ctrl_q[`PTR_CTRL_LOP_MSK_B]);
		end
	end

endmodule // ptr_interp
`default_nettype wire

// ==== testbench/ptr_interp_monitor.sv ====
// port-level assertions for the pointer interpreter
`timescale 1ns/100ps
`default_nettype none
`include "ptr_map.vh"
module ptr_interp_monitor (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// stream framing
	input wire logic        frame_end,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// alarm levels
	input wire logic        path_ais,
	input wire logic        path_lop,
	input wire logic [9:0]  pointer_value
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// bus handshakes: taken at once, answered one cycle later
	property p_write_take;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |->
			(s_axi_awready && s_axi_wready) ##1 s_axi_bvalid;
	endproperty
	a_write_take: assert property (p_write_take) else $error("write not answered");
	property p_write_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_write_refuse: assert property (p_write_refuse) else $error("write taken while busy");
	property p_read_take;
		s_axi_arvalid && !s_axi_rvalid |-> s_axi_arready ##1 s_axi_rvalid;
	endproperty
	a_read_take: assert property (p_read_take) else $error("read not answered");
	property p_read_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_read_refuse: assert property (p_read_refuse) else $error("read taken while busy");
	// answers stand until the master accepts them
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	// levels move only on an evaluated frame or coming out of reset
	property p_frame_hold;
		$past(aresetn) && !frame_end |=> $stable({path_ais, path_lop, pointer_value});
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("state moved off frame");
	property p_alarm_excl;
		!(path_ais && path_lop);
	endproperty
	a_alarm_excl: assert property (p_alarm_excl) else $error("two states at once");

	// main scenarios reached
	c_ais_entry: cover property ($rose(path_ais));
	c_lop_entry: cover property ($rose(path_lop));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `PTR_RESP_SLVERR);
endmodule // ptr_interp_monitor

bind ptr_interp ptr_interp_monitor u_mon (.aclk, .aresetn, .frame_end, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .path_ais, .path_lop, .pointer_value);
`default_nettype wire

// ==== testbench/ptr_line_model.sv ====
// far-end transmitter model sending framed pointer words
`timescale 1ns/100ps
`default_nettype none
module ptr_line_model (
	// clock
	input  wire logic        aclk,
	// framed overhead words
	output var  logic        ptr_strobe,
	output var  logic [15:0] ptr_word,
	output var  logic        ci_strobe,
	output var  logic [15:0] ci_word,
	output var  logic        frame_end
);
	// quiet line at time zero
	initial begin
		ptr_strobe = 1'b0;
		ptr_word   = 16'h0000;
		ci_strobe  = 1'b0;
		ci_word    = 16'h0000;
		frame_end  = 1'b0;
	end

	// primary, one concat pair, frame end, idle; released words show
	// their inverse so a stale word can never pass for a fresh one
	task automatic send_frame(input logic [15:0] w, input logic [15:0] ci, input int gap);
		@(posedge aclk);
		ptr_strobe <= 1'b1;
		ptr_word   <= w;
		@(posedge aclk);
		ptr_strobe <= 1'b0;
		ptr_word   <= ~w;
		ci_strobe  <= 1'b1;
		ci_word    <= ci;
		@(posedge aclk);
		ci_strobe  <= 1'b0;
		ci_word    <= ~ci;
		frame_end  <= 1'b1;
		@(posedge aclk);
		frame_end  <= 1'b0;
		repeat (gap) @(posedge aclk);
	endtask
endmodule // ptr_line_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the pointer interpreter
`timescale 1ns/100ps
`default_nettype none
`include "ptr_map.vh"
module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        ptr_strobe, ci_strobe, frame_end;
	logic [15:0] ptr_word, ci_word;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        path_ais, path_lop, irq_out_a, irq_out_b;
	logic [9:0]  pointer_value;
	int          n_fail = 0;
	int          total_checks = 0;
	int          gap = 0;

	// 25 MHz clock
	always #20 aclk = ~aclk;

	ptr_line_model far_end (.aclk, .ptr_strobe, .ptr_word, .ci_strobe, .ci_word, .frame_end);
	ptr_interp dut (.aclk, .aresetn, .ptr_strobe, .ptr_word, .ci_strobe, .ci_word,
		.frame_end, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .path_ais, .path_lop, .pointer_value,
		.irq_out_a, .irq_out_b);

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// bounded wait on one handshake; 0 aw+w, 1 b, 2 ar, 3 r
	task automatic await(input int k);
		int   i;
		logic hit;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			hit = (k == 0) ? s_axi_awready && s_axi_wready : (k == 1) ? s_axi_bvalid :
				(k == 2) ? s_axi_arready : s_axi_rvalid;
			if (hit)
				break;
		end
		if (i == 50) begin
			n_fail++;
			close_out();
		end
	endtask

	// address and data offered together, response checked
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		await(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		await(1);
		s_axi_bready  <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		await(2);
		s_axi_arvalid <= 1'b0;
		await(3);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready  <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, `PTR_RESP_OKAY});
	endtask

	// n frames, judged once the evaluating edge has landed
	task automatic frn(input int n, input logic [15:0] w, input logic [15:0] ci);
		repeat (n) far_end.send_frame(w, ci, gap);
		@(negedge aclk);
	endtask

	task automatic pins(input logic state_alarm_indication, input logic state_loss_of_pointer, input logic [9:0] v);
		chk({30'h0, path_ais, path_lop}, {30'h0, state_alarm_indication, state_loss_of_pointer});
		if (!state_alarm_indication && !state_loss_of_pointer)
			chk({22'h0, pointer_value}, {22'h0, v});
	endtask

	// interrupts lag pending by a cycle
	task automatic irq(input logic a, input logic b);
		repeat (2) @(negedge aclk);
		chk({30'h0, irq_out_a, irq_out_b}, {30'h0, a, b});
	endtask

	task automatic s_reset;
		rdc(`PTR_ADDR_CTRL, 32'h0);
		rdc(`PTR_ADDR_STATUS, 32'h1);
		pins(1'b0, 1'b1, 10'h0);
		wr(`PTR_ADDR_CTRL, 32'h60, `PTR_RESP_OKAY);
	endtask

	task automatic s_state_normal;
		frn(2, 16'h6a0a, 16'h6bff);
		pins(1'b0, 1'b1, 10'h0);
		frn(1, 16'h6a0a, 16'hffff);
		pins(1'b0, 1'b0, 10'h20a);
		irq(1'b1, 1'b0);
		rdc(`PTR_ADDR_STATUS, 32'h020a0000);
		rdc(`PTR_ADDR_ALARM, 32'h2);
		rdc(`PTR_ADDR_ALARM, 32'h0);
		rdc(`PTR_ADDR_PEND, 32'h2);
		irq(1'b0, 1'b0);
		rdc(`PTR_ADDR_PEND, 32'h0);
	endtask

	// sonet justification with hold-off, then a new data flag
	task automatic s_just;
		frn(1, 16'h68a3, 16'h6bff);
		pins(1'b0, 1'b0, 10'h20b);
		frn(1, 16'h6b5e, 16'h6bff);
		pins(1'b0, 1'b0, 10'h20b);
		frn(2, 16'h6a0b, 16'h6bff);
		frn(1, 16'h6b5e, 16'h6bff);
		pins(1'b0, 1'b0, 10'h20a);
		frn(1, 16'h8864, 16'h6bff);
		pins(1'b0, 1'b0, 10'h064);
	endtask

	// sdh majority rules, then eight invalid frames
	task automatic s_sdh;
		int          i;
		logic [31:0] d;
		logic [1:0]  r;
		wr(`PTR_ADDR_CTRL, 32'h61, `PTR_RESP_OKAY);
		frn(3, 16'h6864, 16'h6bff);
		frn(1, 16'h6ac4, 16'h6bff);
		pins(1'b0, 1'b0, 10'h065);
		frn(3, 16'h6865, 16'h6bff);
		frn(1, 16'h6b95, 16'h6bff);
		pins(1'b0, 1'b0, 10'h065);
		frn(1, 16'h6935, 16'h6bff);
		pins(1'b0, 1'b0, 10'h064);
		for (i = 0; i < 8; i++) begin
			if (i == 7)
				pins(1'b0, 1'b0, 10'h064);
			if (i < 4)
				frn(1, 16'h6064, 16'h6bff);
			else
				frn(1, 16'h6864, 16'h1234);
		end
		pins(1'b0, 1'b1, 10'h0);
		rd(`PTR_ADDR_STATUS, d, r);
		chk(d & 32'h13, 32'h11);
	endtask

	// far end slow between frames here
	task automatic s_ais;
		gap = 4;
		frn(2, 16'hffff, 16'hffff);
		pins(1'b0, 1'b1, 10'h0);
		frn(1, 16'hffff, 16'hffff);
		pins(1'b1, 1'b0, 10'h0);
		irq(1'b1, 1'b1);
		rdc(`PTR_ADDR_ALARM, 32'h3);
		rdc(`PTR_ADDR_ALARM, 32'h1);
		rdc(`PTR_ADDR_PEND, 32'h3);
		irq(1'b0, 1'b0);
		frn(3, 16'h6864, 16'h6bff);
		pins(1'b0, 1'b0, 10'h064);
		irq(1'b0, 1'b1);
		gap = 0;
	endtask

	// refused writes and an unmapped read
	task automatic s_bus;
		logic [31:0] d;
		logic [1:0]  r;
		wr(8'h10, 32'h5, `PTR_RESP_SLVERR);
		wr(`PTR_ADDR_STATUS, 32'h0, `PTR_RESP_SLVERR);
		rd(8'h10, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, `PTR_RESP_SLVERR});
		rdc(`PTR_ADDR_CTRL, 32'h61);
		// control write without byte lane 0 leaves control alone
		s_axi_wstrb <= 4'he;
		wr(`PTR_ADDR_CTRL, 32'h0, `PTR_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rdc(`PTR_ADDR_CTRL, 32'h61);
		// write answer must stand while the master stalls
		@(posedge aclk);
		s_axi_awaddr  <= 8'h10;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		await(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		@(posedge aclk);
		s_axi_bready  <= 1'b1;
		await(1);
		s_axi_bready  <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, `PTR_RESP_SLVERR});
		// read answer must stand while the master stalls
		@(posedge aclk);
		s_axi_araddr  <= `PTR_ADDR_CTRL;
		s_axi_arvalid <= 1'b1;
		await(2);
		s_axi_arvalid <= 1'b0;
		repeat (2) @(posedge aclk);
		s_axi_rready  <= 1'b1;
		await(3);
		s_axi_rready  <= 1'b0;
		chk(s_axi_rdata, 32'h61);
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		s_reset();
		s_state_normal();
		s_just();
		s_sdh();
		s_ais();
		s_bus();
		close_out();
	end
endmodule // tb_top
`default_nettype wire
